// [hdl/spbc_cfg.svh]
// Register offsets, field positions, reset values and masks of the pin and baud block
`ifndef SPBC_CFG_SVH
`define SPBC_CFG_SVH

`define SPBC_ADDR_W 8
`define SPBC_DATA_W 8

`define SPBC_ADDR_CTRL2 8'h00
`define SPBC_ADDR_BAUD 8'h01
`define SPBC_ADDR_MODE 8'h02
`define SPBC_ADDR_STATUS 8'h03

`define SPBC_CTRL2_RESET 8'h00
`define SPBC_BAUD_RESET 8'h00
`define SPBC_MODE_RESET 8'h00
`define SPBC_READ_ZERO 8'h00

`define SPBC_CTRL2_MASK 8'h1B
`define SPBC_BAUD_MASK 8'h77
`define SPBC_MODE_MASK 8'h07

`define SPBC_FAULT_EN_BIT 4
`define SPBC_DRIVE_EN_BIT 3
`define SPBC_HALT_WAIT_BIT 1
`define SPBC_SINGLE_WIRE_BIT 0

`define SPBC_PRESCALE_HI 6
`define SPBC_PRESCALE_LO 4
`define SPBC_DIVIDE_HI 2
`define SPBC_DIVIDE_LO 0

`define SPBC_ENABLE_BIT 0
`define SPBC_MASTER_BIT 1
`define SPBC_SEL_OUT_EN_BIT 2

`define SPBC_ST_RUN_BIT 0
`define SPBC_ST_HALT_BIT 1
`define SPBC_ST_SCLK_OWN_BIT 2
`define SPBC_ST_MOSI_OWN_BIT 3
`define SPBC_ST_MISO_OWN_BIT 4
`define SPBC_ST_SS_OWN_BIT 5

`endif

// [hdl/spbc_pkg.sv]
// Types shared by the pin and baud block
package spbc_pkg;

    // One pin as seen by the port logic: owned=0 hands it back to general-purpose control
    typedef struct packed {
        logic owned;
        logic drive;
        logic level;
    } spbc_pin_t;

endpackage

// [hdl/spbc_divider.sv]
// One divider stage: pulses on every limit-th step
`timescale 1ns/10ps
module spbc_divider #(
    parameter int W = 4
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic clear_i,
    input wire logic step_i,
    input wire logic [W-1:0] limit_i,
    output logic tick_o
);
    logic [W-1:0] count;
    logic at_end;

    // A limit of zero behaves as one
    assign at_end = (count >= (limit_i - W'(1))) || (limit_i == '0);
    assign tick_o = step_i && at_end;

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || clear_i) begin
            count <= '0;
        end else if (step_i) begin
            if (at_end) begin
                count <= '0;
            end else begin
                count <= count + W'(1);
            end
        end
    end
endmodule

// [hdl/spbc_top.sv]
// Pin role selection and two-stage baud clock for the serial peripheral port
//
// Overview of operation
// - As slave, the select pin is an active-low select input.
// - Master with fault detect off: select pin goes back to general-purpose control.
// - Master with fault detect on: select pin is fault input, or select output if enabled.
// - Fault detect enable (control two, bit 4) has no effect in slave mode.
// - Bit 0 clear uses separate data pins; set uses one shared data wire.
// - Single wire uses the MOSI pin as master, the MISO pin as slave.
// - Single wire: drive enable bit 3 low makes the pin input, high drives it.
// - The single-wire drive enable is ignored with separate pins.
// - Halt-in-wait bit 1 clear keeps clocks in wait; set stops them.
// - The baud register may be read and written at any time.
// - Bits 6 to 4 pick one of eight prescaler divisors of the bus clock.
// - Bits 2 to 0 pick one of eight second-stage divisors giving the bit clock.
// - The baud settings act only in master mode, making the serial clock.
// - With the interface disabled all four pins return to general-purpose control.
// - Serial clock pin is an output as master, an input as slave.
// - Single wire: the unused data pin returns to general-purpose control.
`timescale 1ns/10ps
`include "spbc_cfg.svh"
module spbc_top #(
    parameter logic [7:0][3:0] PRESCALE_TABLE = {4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1},
    parameter logic [7:0][8:0] DIVIDE_TABLE = {9'h100, 9'h080, 9'h040, 9'h020,
                                               9'h010, 9'h008, 9'h004, 9'h002}
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [`SPBC_ADDR_W-1:0] addr_i,
    input wire logic [`SPBC_DATA_W-1:0] wr_data_i,
    input wire logic wr_stb_i,
    input wire logic rd_stb_i,
    output logic [`SPBC_DATA_W-1:0] rd_data_o,
    input wire logic wait_mode_i,
    input wire logic tx_bit_i,
    input wire logic select_assert_i,
    input wire logic serial_clock_pin_i,
    input wire logic mosi_pin_i,
    input wire logic miso_pin_i,
    input wire logic select_pin_n_i,
    output spbc_pkg::spbc_pin_t serial_clock_pin_o,
    output spbc_pkg::spbc_pin_t mosi_pin_o,
    output spbc_pkg::spbc_pin_t miso_pin_o,
    output spbc_pkg::spbc_pin_t select_pin_o,
    output logic rx_bit_o,
    output logic serial_clock_in_o,
    output logic select_active_o,
    output logic fault_level_o,
    output logic bit_tick_o,
    output logic clocks_run_o
);
    import spbc_pkg::*;

    logic [7:0] control_two;
    logic [7:0] baud_select;
    logic [7:0] mode_ctrl;
    logic [7:0] status_word;
    logic interface_enable;
    logic master_select;
    logic select_output_enable;
    logic fault_detect_enable;
    logic single_wire_drive_enable;
    logic halt_in_wait;
    logic single_wire_select;
    logic [2:0] baud_prescale_field;
    logic [2:0] baud_divide_field;
    logic halted;
    logic run;
    logic baud_write;
    logic clear;
    logic pre_tick;
    logic div_tick;
    logic serial_clock;
    logic [12:0] total_div;
    logic [12:0] gap_cnt;
    spbc_pin_t next_sclk;
    spbc_pin_t next_mosi;
    spbc_pin_t next_miso;
    spbc_pin_t next_ss;
    logic next_rx;
    logic next_sclk_in;
    logic next_sel_active;
    logic next_fault;

    assign interface_enable = mode_ctrl[`SPBC_ENABLE_BIT];
    assign master_select = mode_ctrl[`SPBC_MASTER_BIT];
    assign select_output_enable = mode_ctrl[`SPBC_SEL_OUT_EN_BIT];
    assign fault_detect_enable = control_two[`SPBC_FAULT_EN_BIT];
    assign single_wire_drive_enable = control_two[`SPBC_DRIVE_EN_BIT];
    assign halt_in_wait = control_two[`SPBC_HALT_WAIT_BIT];
    assign single_wire_select = control_two[`SPBC_SINGLE_WIRE_BIT];
    assign baud_prescale_field = baud_select[`SPBC_PRESCALE_HI:`SPBC_PRESCALE_LO];
    assign baud_divide_field = baud_select[`SPBC_DIVIDE_HI:`SPBC_DIVIDE_LO];

    // Register writes; no state gates them, so the baud divisors can be retuned live
    assign baud_write = wr_stb_i && (addr_i == `SPBC_ADDR_BAUD);

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            control_two <= `SPBC_CTRL2_RESET;
        end else if (wr_stb_i && (addr_i == `SPBC_ADDR_CTRL2)) begin
            control_two <= wr_data_i & `SPBC_CTRL2_MASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            baud_select <= `SPBC_BAUD_RESET;
        end else if (baud_write) begin
            baud_select <= wr_data_i & `SPBC_BAUD_MASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            mode_ctrl <= `SPBC_MODE_RESET;
        end else if (wr_stb_i && (addr_i == `SPBC_ADDR_MODE)) begin
            mode_ctrl <= wr_data_i & `SPBC_MODE_MASK;
        end
    end

    always_comb begin
        status_word = `SPBC_READ_ZERO;
        status_word[`SPBC_ST_RUN_BIT] = clocks_run_o;
        status_word[`SPBC_ST_HALT_BIT] = halted;
        status_word[`SPBC_ST_SCLK_OWN_BIT] = serial_clock_pin_o.owned;
        status_word[`SPBC_ST_MOSI_OWN_BIT] = mosi_pin_o.owned;
        status_word[`SPBC_ST_MISO_OWN_BIT] = miso_pin_o.owned;
        status_word[`SPBC_ST_SS_OWN_BIT] = select_pin_o.owned;
    end

    // Read data stands only in the cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || !rd_stb_i) begin
            rd_data_o <= `SPBC_READ_ZERO;
        end else if (addr_i == `SPBC_ADDR_CTRL2) begin
            rd_data_o <= control_two;
        end else if (addr_i == `SPBC_ADDR_BAUD) begin
            rd_data_o <= baud_select;
        end else if (addr_i == `SPBC_ADDR_MODE) begin
            rd_data_o <= mode_ctrl;
        end else if (addr_i == `SPBC_ADDR_STATUS) begin
            rd_data_o <= status_word;
        end else begin
            rd_data_o <= `SPBC_READ_ZERO;
        end
    end

    // Wait mode is a level; clocks stop while it stands and halting is allowed
    assign halted = halt_in_wait && wait_mode_i;
    assign run = interface_enable && master_select && !halted;
    // Retuning restarts both stages so the first bit after a change has the new length
    assign clear = !run || baud_write;

    spbc_divider #(
        .W(4)
    ) u_prescale (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .clear_i(clear),
        .step_i(run),
        .limit_i(PRESCALE_TABLE[baud_prescale_field]),
        .tick_o(pre_tick)
    );

    spbc_divider #(
        .W(9)
    ) u_divide (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .clear_i(clear),
        .step_i(pre_tick),
        .limit_i(DIVIDE_TABLE[baud_divide_field]),
        .tick_o(div_tick)
    );

    // Serial clock toggles on every bit tick and idles low when stopped
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || !run) begin
            serial_clock <= 1'b0;
        end else if (div_tick) begin
            serial_clock <= !serial_clock;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            bit_tick_o <= 1'b0;
            clocks_run_o <= 1'b0;
        end else begin
            bit_tick_o <= div_tick;
            clocks_run_o <= run;
        end
    end

    // Pin roles
    always_comb begin
        next_sclk = '0;
        next_mosi = '0;
        next_miso = '0;
        next_ss = '0;
        next_rx = 1'b0;
        next_sclk_in = 1'b0;
        next_sel_active = 1'b0;
        next_fault = 1'b0;
        if (interface_enable) begin
            next_sclk.owned = 1'b1;
            if (master_select) begin
                next_sclk.drive = 1'b1;
                next_sclk.level = serial_clock;
                if (!single_wire_select) begin
                    next_mosi = '{owned: 1'b1, drive: 1'b1, level: tx_bit_i};
                    next_miso.owned = 1'b1;
                    next_rx = miso_pin_i;
                end else begin
                    next_mosi = '{owned: 1'b1, drive: single_wire_drive_enable, level: tx_bit_i};
                    next_rx = mosi_pin_i;
                end
                if (fault_detect_enable) begin
                    next_ss.owned = 1'b1;
                    if (select_output_enable) begin
                        next_ss.drive = 1'b1;
                        next_ss.level = !select_assert_i;
                    end else begin
                        next_fault = select_pin_n_i;
                    end
                end
            end else begin
                next_sclk_in = serial_clock_pin_i;
                next_ss.owned = 1'b1;
                next_sel_active = !select_pin_n_i;
                if (!single_wire_select) begin
                    next_mosi.owned = 1'b1;
                    next_rx = mosi_pin_i;
                    // Output only while selected, so unselected slaves share the line
                    next_miso = '{owned: 1'b1, drive: !select_pin_n_i, level: tx_bit_i};
                end else begin
                    next_miso = '{owned: 1'b1, drive: single_wire_drive_enable, level: tx_bit_i};
                    next_rx = miso_pin_i;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            serial_clock_pin_o <= '0;
            mosi_pin_o <= '0;
            miso_pin_o <= '0;
            select_pin_o <= '0;
        end else begin
            serial_clock_pin_o <= next_sclk;
            mosi_pin_o <= next_mosi;
            miso_pin_o <= next_miso;
            select_pin_o <= next_ss;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            rx_bit_o <= 1'b0;
            serial_clock_in_o <= 1'b0;
            select_active_o <= 1'b0;
            fault_level_o <= 1'b0;
        end else begin
            rx_bit_o <= next_rx;
            serial_clock_in_o <= next_sclk_in;
            select_active_o <= next_sel_active;
            fault_level_o <= next_fault;
        end
    end

    // Helper for the bit period check
    assign total_div = 13'(PRESCALE_TABLE[baud_prescale_field] * DIVIDE_TABLE[baud_divide_field]);

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || clear || div_tick) begin
            gap_cnt <= '0;
        end else begin
            gap_cnt <= gap_cnt + 13'h0001;
        end
    end

    a_bit_period: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (div_tick && !clear) |-> (gap_cnt == total_div - 13'h0001))
        else $error("bit tick period differs from product of divisors");

    a_slave_select_in: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (interface_enable && !master_select) |=>
        (select_pin_o.owned && !select_pin_o.drive && select_active_o == !$past(select_pin_n_i)))
        else $error("slave select input not followed");

    a_master_ss_free: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (interface_enable && master_select && !fault_detect_enable) |=> !select_pin_o.owned)
        else $error("select pin kept while fault detect off");

    a_fault_input: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (interface_enable && master_select && fault_detect_enable && !select_output_enable) |=>
        (select_pin_o.owned && !select_pin_o.drive && fault_level_o == $past(select_pin_n_i)))
        else $error("fault input role wrong");

    a_select_output: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (interface_enable && master_select && fault_detect_enable && select_output_enable) |=>
        (select_pin_o.drive && select_pin_o.level == !$past(select_assert_i)))
        else $error("select output not driven");

    a_slave_no_fault: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (interface_enable && !master_select && fault_detect_enable) |=>
        (!select_pin_o.drive && !fault_level_o))
        else $error("fault enable acted in slave mode");

    a_separate_pins: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (interface_enable && master_select && !single_wire_select) |=>
        (mosi_pin_o.drive && miso_pin_o.owned && !miso_pin_o.drive && rx_bit_o == $past(miso_pin_i)))
        else $error("separate pin roles wrong");

    a_shared_pin: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (interface_enable && single_wire_select) |=>
        (mosi_pin_o.owned == $past(master_select) && miso_pin_o.owned == !$past(master_select)))
        else $error("shared data pin choice wrong");

    a_shared_drive: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (interface_enable && single_wire_select) |=>
        ((mosi_pin_o.drive || miso_pin_o.drive) == $past(single_wire_drive_enable)))
        else $error("shared pin drive not per enable");

    a_drive_ignored: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (interface_enable && master_select && !single_wire_select && !single_wire_drive_enable)
        |=> mosi_pin_o.drive)
        else $error("drive enable acted with separate pins");

    a_wait_halt: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (halt_in_wait && wait_mode_i) |=> (!clocks_run_o && !bit_tick_o))
        else $error("clocks ran while halted in wait");

    a_wait_run: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (interface_enable && master_select && !halt_in_wait) |=> clocks_run_o)
        else $error("clocks stopped without halt bit");

    a_baud_readback: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (wr_stb_i && addr_i == `SPBC_ADDR_BAUD) ##1 (rd_stb_i && addr_i == `SPBC_ADDR_BAUD) |=>
        (rd_data_o == ($past(wr_data_i, 2) & `SPBC_BAUD_MASK)))
        else $error("baud register readback wrong");

    a_slave_no_clock: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !master_select |=> (!bit_tick_o && !serial_clock_pin_o.drive))
        else $error("slave generated serial clock");

    a_disable_release: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !interface_enable |=> !(serial_clock_pin_o.owned || mosi_pin_o.owned ||
                                miso_pin_o.owned || select_pin_o.owned))
        else $error("pin held while interface disabled");

    a_master_clock_out: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (interface_enable && master_select) |=> (serial_clock_pin_o.owned && serial_clock_pin_o.drive))
        else $error("master does not drive serial clock");
endmodule

// [sim/spbc_peer.sv]
// Far-side serial peer and resolution of the four shared pin wires
`timescale 1ns/10ps
module spbc_peer #(
    parameter int HALF = 3
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic master_i,
    input wire logic select_i,
    input wire logic [1:0] data_en_i,
    input wire logic data_i,
    input spbc_pkg::spbc_pin_t [3:0] dut_pin_i,
    output logic [3:0] wire_o
);
    import spbc_pkg::*;
    logic [3:0] peer_en;
    logic [3:0] peer_val;
    logic [3:0] last;
    logic sclk_q;
    int cnt;
    // Peer clock stands still low outside a frame
    always_ff @(posedge clk_sys_i) begin
        if (!select_i) begin
            cnt <= 0;
            sclk_q <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            sclk_q <= ~sclk_q;
        end else begin
            cnt <= cnt + 1;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            last <= 4'h0;
        end else begin
            last <= wire_o;
        end
    end
    // Order: ss, miso, mosi, sclk; a peer master owns clock and select
    assign peer_en = {master_i, data_en_i, master_i};
    assign peer_val = {~select_i, data_i, data_i, sclk_q};
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (dut_pin_i[i].owned && dut_pin_i[i].drive) begin
                wire_o[i] = dut_pin_i[i].level;
            end else if (peer_en[i]) begin
                wire_o[i] = peer_val[i];
            end else begin
                // Undriven line flips each cycle so a stale value never passes
                wire_o[i] = ~last[i];
            end
        end
    end
endmodule

// [sim/spbc_top_tb.sv]
// Register, pin role and baud checks of the pin and baud block
`timescale 1ns/10ps
`include "spbc_cfg.svh"
module spbc_top_tb;
    import spbc_pkg::*;
    localparam logic [7:0][3:0] PTAB = {4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
    localparam logic [7:0][8:0] DTAB = {9'h100, 9'h080, 9'h040, 9'h020,
                                        9'h010, 9'h008, 9'h004, 9'h002};
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wr_data_i = 8'h00;
    logic wr_stb_i = 1'b0;
    logic rd_stb_i = 1'b0;
    logic wait_mode_i = 1'b0;
    logic tx_bit_i = 1'b0;
    logic select_assert_i = 1'b0;
    logic peer_master = 1'b0;
    logic peer_select = 1'b0;
    logic [1:0] peer_data_en = 2'h0;
    logic peer_data = 1'b0;
    logic [7:0] rd_data_o;
    spbc_pin_t [3:0] pins;
    logic [3:0] wires;
    logic rx_bit_o, serial_clock_in_o, select_active_o, fault_level_o, bit_tick_o, clocks_run_o;
    int mismatches = 0;
    int compares = 0;

    spbc_top #(.PRESCALE_TABLE(PTAB), .DIVIDE_TABLE(DTAB)) i_spbc_top (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
        .rd_data_o(rd_data_o), .wait_mode_i(wait_mode_i), .tx_bit_i(tx_bit_i),
        .select_assert_i(select_assert_i), .serial_clock_pin_i(wires[0]),
        .mosi_pin_i(wires[1]), .miso_pin_i(wires[2]), .select_pin_n_i(wires[3]),
        .serial_clock_pin_o(pins[0]), .mosi_pin_o(pins[1]), .miso_pin_o(pins[2]),
        .select_pin_o(pins[3]), .rx_bit_o(rx_bit_o), .serial_clock_in_o(serial_clock_in_o),
        .select_active_o(select_active_o), .fault_level_o(fault_level_o),
        .bit_tick_o(bit_tick_o), .clocks_run_o(clocks_run_o)
    );
    spbc_peer i_spbc_peer (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .master_i(peer_master),
        .select_i(peer_select), .data_en_i(peer_data_en), .data_i(peer_data),
        .dut_pin_i(pins), .wire_o(wires)
    );

    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    task automatic report_and_stop();
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Two bits a pin, ss..sclk: 3 driven, 2 owned input, 0 released
    task automatic chkp(input logic [7:0] exp);
        chk("pin_roles", exp, {pins[3][2:1], pins[2][2:1], pins[1][2:1], pins[0][2:1]});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_stb_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_stb_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_stb_i <= 1'b0;
        #1;
        chk("rd_data", exp, rd_data_o);
    endtask
    // Write then read with no gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge clk_sys_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_stb_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_stb_i <= 1'b0;
        rd_stb_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_stb_i <= 1'b0;
        #1;
        chk("wr_rd_data", exp, rd_data_o);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    // Bit period is the edge count between two consecutive ticks
    task automatic meas(input int p, input int d);
        int n;
        logic s;
        wr(8'h01, {1'b0, p[2:0], 1'b0, d[2:0]});
        n = 0;
        s = 1'b0;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge clk_sys_i);
                #1;
                n++;
            end while (bit_tick_o !== 1'b1 && n < 5000);
            if (n >= 5000) begin
                mismatches++;
                report_and_stop();
            end
            // Pin level lags the tick by one cycle, so it shows the pre-tick clock here
            if (k == 0) begin
                s = pins[0].level;
            end
        end
        chk("bit_period", PTAB[p] * DTAB[d], n[15:0]);
        chk("sclk_level", !s, pins[0].level);
    endtask

    initial begin
        logic w;
        int t;
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        // All reads first: once the mode is written the status word is no longer zero
        for (int a = 0; a < 5; a++) rd(a[7:0], 8'h00);
        for (int a = 0; a < 5; a++) wr(a[7:0], 8'hFF);
        rd(8'h00, 8'h1B);
        rd(8'h01, 8'h77);
        rd(8'h02, 8'h07);
        rd(8'h04, 8'h00);
        wr(8'h02, 8'h00);
        settle();
        chkp(8'h00);
        // Slave, separate pins, fault enable set but meaningless here
        wr(8'h00, 8'h10);
        wr(8'h02, 8'h01);
        peer_master <= 1'b1;
        peer_data_en <= 2'h1;
        peer_data <= 1'b1;
        tx_bit_i <= 1'b1;
        settle();
        chkp(8'hAA);
        chk("select_active", 16'h0, select_active_o);
        peer_select <= 1'b1;
        settle();
        chkp(8'hBA);
        chk("miso_level", 16'h1, pins[2].level);
        chk("select_active", 16'h1, select_active_o);
        chk("rx_bit", 16'h1, rx_bit_o);
        repeat (8) begin
            w = wires[0];
            @(posedge clk_sys_i);
            #1;
            chk("sclk_in", w, serial_clock_in_o);
            chk("tick", 16'h0, bit_tick_o);
        end
        // Slave, single wire on the slave data pin
        wr(8'h00, 8'h09);
        peer_data_en <= 2'h2;
        settle();
        chkp(8'hB2);
        wr(8'h00, 8'h01);
        peer_data <= 1'b0;
        settle();
        chkp(8'hA2);
        chk("rx_bit", 16'h0, rx_bit_o);
        // Master, separate pins, drive enable set but ignored
        peer_master <= 1'b0;
        peer_select <= 1'b0;
        wr(8'h00, 8'h08);
        wr(8'h02, 8'h03);
        settle();
        chkp(8'h2F);
        chk("mosi_level", 16'h1, pins[1].level);
        chk("rx_bit", 16'h0, rx_bit_o);
        rd(8'h03, 8'h1D);
        // Master with fault detect: select pin as fault input, then as select output
        wr(8'h00, 8'h10);
        peer_master <= 1'b1;
        settle();
        chkp(8'hAF);
        chk("fault_level", 16'h1, fault_level_o);
        peer_select <= 1'b1;
        settle();
        chk("fault_level", 16'h0, fault_level_o);
        peer_master <= 1'b0;
        peer_select <= 1'b0;
        wr(8'h02, 8'h07);
        select_assert_i <= 1'b1;
        settle();
        chkp(8'hEF);
        chk("ss_level", 16'h0, pins[3].level);
        select_assert_i <= 1'b0;
        settle();
        chk("ss_level", 16'h1, pins[3].level);
        // Master, single wire on the master data pin
        wr(8'h00, 8'h19);
        settle();
        chkp(8'hCF);
        wr(8'h00, 8'h11);
        peer_data_en <= 2'h1;
        peer_data <= 1'b1;
        settle();
        chkp(8'hCB);
        chk("rx_bit", 16'h1, rx_bit_o);
        // Clocks stop in wait only with halt set
        wr(8'h02, 8'h03);
        wr(8'h00, 8'h02);
        wait_mode_i <= 1'b1;
        settle();
        chk("clocks_run", 16'h0, clocks_run_o);
        rd(8'h03, 8'h1E);
        t = 0;
        repeat (40) begin
            @(posedge clk_sys_i);
            #1;
            if (bit_tick_o === 1'b1) t++;
        end
        chk("ticks", 16'h0, t[15:0]);
        wr(8'h00, 8'h00);
        settle();
        chk("clocks_run", 16'h1, clocks_run_o);
        for (int p = 0; p < 8; p++) meas(p, 0);
        for (int d = 1; d < 8; d++) meas(0, d);
        meas(7, 7);
        rd(8'h01, 8'h77);
        wr_rd(8'h01, 8'hB5, 8'h35);
        report_and_stop();
    end
endmodule
